// ### verilog/qrst_switch_timing.sv
// switch-on timing core: soft start, up/down and valley counters, gate control
`timescale 1ns/1ns
`default_nettype none
// How it works
// - soft start lasts 12 ms in 4 steps
// - current limit steps from 0.3 V up to 1 V
// - first 3 ms force 25 us suppression
// - minimum count 1 low line, 3 high line
// - line decision uses hysteresis and blanking
// - feedback judged once per 48 ms period
// - always below up threshold: count up, saturate
// - above up, never above down: hold
// - above down, never above preset: count down
// - above preset: load minimum immediately
// - counter confined to 1..8 or 3..10
// - start-up loads counter with line minimum
// - falling valley crossings after turn-off count up
// - valley counter cleared on gate rising
// - valley counter bounded by line mode maximum
// - suppression long below select threshold, else short
// - gate held low during suppression time
// - after suppression, on when counters match
// - maximum off time forces gate on
// - on from counters, off from current sense
// - soft start begins when supply passes threshold
// - current sense above feedback turns gate off
// - maximum on time forces gate off
module qrst_switch_timing
    import qrst_pkg::*;
#(
    parameter int SS_CYCLES = SOFT_START_CYCLES,
    parameter int SS_WINDOW_CYCLES = SS_FIXED_SUPP_WINDOW_CYCLES,
    parameter int PERIOD_CYCLES = COUNTER_PERIOD_CYCLES,
    parameter int LINE_BLANK_CYCLES = LINE_SELECT_BLANKING_CYCLES
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // supply and line comparators
    input wire logic i_vcc_above_on,
    input wire logic i_line_above_ref,
    input wire logic i_line_below_ref,
    // feedback comparators
    input wire logic i_fb_above_count_up,
    input wire logic i_fb_above_count_down,
    input wire logic i_fb_above_preset,
    // valley and current comparators
    input wire logic i_valley_below_detect,
    input wire logic i_valley_below_select,
    input wire logic i_cs_above_feedback,
    // outputs
    output logic o_gate_drive,
    output logic [MV_W-1:0] o_cs_limit_mv,
    output logic o_soft_start_active,
    output logic o_high_line,
    output logic [CNT_W-1:0] o_updown_count,
    output logic [CNT_W-1:0] o_valley_count
);
    // ------------------------------------------------------------------
    // sizes and limits
    // ------------------------------------------------------------------
    localparam int SSW = $clog2(SS_CYCLES + 1);
    localparam int STW = $clog2(SS_CYCLES / SOFT_START_STEPS + 1);
    localparam int PW = $clog2(PERIOD_CYCLES + 1);
    localparam int TW = 12;
    localparam logic [SSW-1:0] SS_LAST = SSW'(SS_CYCLES - 1);
    localparam logic [SSW-1:0] SS_WINDOW = SSW'(SS_WINDOW_CYCLES);
    localparam logic [STW-1:0] STEP_LAST = STW'(SS_CYCLES / SOFT_START_STEPS - 1);
    localparam logic [1:0] STEP_FINAL = 2'(SOFT_START_STEPS - 1);
    localparam logic [PW-1:0] PERIOD_LAST = PW'(PERIOD_CYCLES - 1);
    localparam logic [TW-1:0] SUPP_FIXED = TW'(SS_FIXED_SUPP_CYCLES);
    localparam logic [TW-1:0] SUPP_SHORT = TW'(SHORT_SUPPRESSION_CYCLES);
    localparam logic [TW-1:0] SUPP_LONG = TW'(LONG_SUPPRESSION_CYCLES);
    localparam logic [TW-1:0] OFF_MAX = TW'(MAX_OFF_CYCLES);
    localparam logic [TW-1:0] ON_MAX = TW'(MAX_ON_CYCLES);

    if (SOFT_START_STEPS != 4 || SS_CYCLES < SOFT_START_STEPS || SS_WINDOW_CYCLES > SS_CYCLES
        || PERIOD_CYCLES < 2 || LINE_BLANK_CYCLES < 1) begin : g_chk
        $error("qrst_switch_timing: unsupported timing parameters");
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [6:0] pin_meta_q;
    logic [6:0] pin_sync_q;
    logic vcc_on;
    logic fb_up;
    logic fb_down;
    logic fb_preset;
    logic valley_below;
    logic select_below;
    logic cs_trip;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_meta_q <= 7'h00;
            pin_sync_q <= 7'h00;
        end else if (i_ce) begin
            pin_meta_q <= {i_vcc_above_on, i_fb_above_count_up, i_fb_above_count_down, i_fb_above_preset,
                i_valley_below_detect, i_valley_below_select, i_cs_above_feedback};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign {vcc_on, fb_up, fb_down, fb_preset, valley_below, select_below, cs_trip} = pin_sync_q;

    // ------------------------------------------------------------------
    // line mode
    // ------------------------------------------------------------------
    qrst_line_if line_bus ();

    qrst_line_sel #(
        .BLANK_CYCLES(LINE_BLANK_CYCLES)
    ) u_line_sel (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_line_above_ref(i_line_above_ref),
        .i_line_below_ref(i_line_below_ref),
        .line(line_bus.sel)
    );

    // ------------------------------------------------------------------
    // core state
    // ------------------------------------------------------------------
    qrst_gate_state_type state_q;
    qrst_gate_state_type state_d;
    logic gate_q;
    logic gate_d;
    logic ss_active_q;
    logic ss_active_d;
    logic [SSW-1:0] ss_cnt_q;
    logic [SSW-1:0] ss_cnt_d;
    logic [STW-1:0] step_tmr_q;
    logic [STW-1:0] step_tmr_d;
    logic [1:0] step_q;
    logic [1:0] step_d;
    logic [MV_W-1:0] cs_mv_q;
    logic [MV_W-1:0] cs_mv_d;
    logic [PW-1:0] period_q;
    logic [PW-1:0] period_d;
    logic [2:0] fb_flags_q;
    logic [2:0] fb_flags_d;
    logic [CNT_W-1:0] ud_q;
    logic [CNT_W-1:0] ud_d;
    logic [CNT_W-1:0] valley_q;
    logic [CNT_W-1:0] valley_d;
    logic valley_prev_q;
    logic [TW-1:0] tmr_q;
    logic [TW-1:0] tmr_d;
    logic [TW-1:0] supp_len;
    logic hl;
    // mode as shown at the pins lags one cycle so the clamped counters match it
    logic hl_q;

    always_comb begin
        hl = line_bus.high_line;
        state_d = state_q;
        gate_d = gate_q;
        ss_active_d = ss_active_q;
        ss_cnt_d = ss_cnt_q;
        step_tmr_d = step_tmr_q;
        step_d = step_q;
        period_d = period_q;
        fb_flags_d = fb_flags_q;
        ud_d = ud_q;
        valley_d = valley_q;
        tmr_d = tmr_q;
        // the fixed time only covers the early soft start, when the output
        // is still low and the ringing is poorly damped
        if (ss_active_q && ss_cnt_q < SS_WINDOW) begin
            supp_len = SUPP_FIXED;
        end else if (select_below) begin
            supp_len = SUPP_LONG;
        end else begin
            supp_len = SUPP_SHORT;
        end

        if (!vcc_on) begin
            state_d = GS_IDLE;
            gate_d = 1'b0;
            ss_active_d = 1'b0;
        end else if (state_q == GS_IDLE) begin
            // supply just came up: fresh soft start from the lowest level
            ss_active_d = 1'b1;
            ss_cnt_d = '0;
            step_tmr_d = '0;
            step_d = 2'h0;
            period_d = '0;
            fb_flags_d = 3'h0;
            ud_d = cnt_min(hl);
            valley_d = CNT_ZERO;
            tmr_d = '0;
            gate_d = 1'b1;
            state_d = GS_ON;
        end else begin
            // soft start steps
            if (ss_active_q) begin
                ss_cnt_d = ss_cnt_q + SSW'(1);
                if (step_tmr_q == STEP_LAST) begin
                    step_tmr_d = '0;
                    if (step_q != STEP_FINAL) begin
                        step_d = step_q + 2'h1;
                    end
                end else begin
                    step_tmr_d = step_tmr_q + STW'(1);
                end
                if (ss_cnt_q == SS_LAST) begin
                    ss_active_d = 1'b0;
                end
            end

            // up/down counter, judged over one period
            fb_flags_d = fb_flags_q | {fb_preset, fb_down, fb_up};
            if (period_q == PERIOD_LAST) begin
                period_d = '0;
                if (!fb_flags_d[0]) begin
                    if (ud_q < cnt_max(hl)) begin
                        ud_d = ud_q + CNT_ONE;
                    end
                end else if (!fb_flags_d[1]) begin
                    ud_d = ud_q;
                end else if (!fb_flags_d[2]) begin
                    if (ud_q > cnt_min(hl)) begin
                        ud_d = ud_q - CNT_ONE;
                    end
                end
                fb_flags_d = 3'h0;
            end else begin
                period_d = period_q + PW'(1);
            end
            // a load step must not wait for the period to end
            if (fb_preset) begin
                ud_d = cnt_min(hl);
            end
            if (line_bus.changed) begin
                ud_d = cnt_clamp(ud_d, hl);
            end

            // valley crossings while the switch is off
            if (state_q != GS_ON && valley_below && !valley_prev_q && valley_q < cnt_max(hl)) begin
                valley_d = valley_q + CNT_ONE;
            end
            if (line_bus.changed && valley_d > cnt_max(hl)) begin
                valley_d = cnt_max(hl);
            end

            // gate sequencing: on from the counters, off from current sense
            case (state_q)
                GS_ON: begin
                    tmr_d = tmr_q + TW'(1);
                    if (cs_trip || tmr_q >= ON_MAX) begin
                        gate_d = 1'b0;
                        tmr_d = '0;
                        state_d = GS_SUPPRESS;
                    end
                end
                GS_SUPPRESS, GS_WAIT: begin
                    tmr_d = (tmr_q == OFF_MAX) ? tmr_q : tmr_q + TW'(1);
                    if (state_q == GS_SUPPRESS && tmr_q + TW'(1) >= supp_len) begin
                        state_d = GS_WAIT;
                    end
                    if (tmr_q + TW'(1) >= OFF_MAX) begin
                        gate_d = 1'b1;
                    end else if (state_q == GS_WAIT && valley_q == ud_q) begin
                        gate_d = 1'b1;
                    end
                    if (gate_d) begin
                        valley_d = CNT_ZERO;
                        tmr_d = '0;
                        state_d = GS_ON;
                    end
                end
                default: begin
                    state_d = GS_IDLE;
                    gate_d = 1'b0;
                end
            endcase
        end
        cs_mv_d = ss_active_d ? step_level(step_d) : CS_LIMIT_FINAL_MV;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= GS_IDLE;
            gate_q <= 1'b0;
            ss_active_q <= 1'b0;
            ss_cnt_q <= '0;
            step_tmr_q <= '0;
            step_q <= 2'h0;
            cs_mv_q <= CS_LIMIT_START_MV;
            period_q <= '0;
            fb_flags_q <= 3'h0;
            ud_q <= CNT_MIN_LOW;
            valley_q <= CNT_ZERO;
            valley_prev_q <= 1'b0;
            tmr_q <= '0;
            hl_q <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            gate_q <= gate_d;
            ss_active_q <= ss_active_d;
            ss_cnt_q <= ss_cnt_d;
            step_tmr_q <= step_tmr_d;
            step_q <= step_d;
            cs_mv_q <= cs_mv_d;
            period_q <= period_d;
            fb_flags_q <= fb_flags_d;
            ud_q <= ud_d;
            valley_q <= valley_d;
            valley_prev_q <= valley_below;
            tmr_q <= tmr_d;
            hl_q <= hl;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_gate_drive = gate_q;
    assign o_cs_limit_mv = cs_mv_q;
    assign o_soft_start_active = ss_active_q;
    assign o_high_line = hl_q;
    assign o_updown_count = ud_q;
    assign o_valley_count = valley_q;

endmodule : qrst_switch_timing
`default_nettype wire

// ### verilog/qrst_pkg.sv
// constants, types and helpers shared by the quasi-resonant switch timing block
package qrst_pkg;

    // ------------------------------------------------------------------
    // clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;

    // ------------------------------------------------------------------
    // times in their own units
    // ------------------------------------------------------------------
    localparam int SOFT_START_TIME_US = 12000;
    localparam int SOFT_START_STEPS = 4;
    localparam int SS_FIXED_SUPP_WINDOW_US = 3000;
    localparam int SS_FIXED_SUPP_TIME_NS = 25000;
    localparam int COUNTER_PERIOD_US = 48000;
    localparam int LINE_SELECT_BLANKING_US = 10000;
    localparam int SHORT_SUPPRESSION_TIME_NS = 2500;
    localparam int LONG_SUPPRESSION_TIME_NS = 25000;
    localparam int MAX_OFF_TIME_NS = 50000;
    localparam int MAX_ON_TIME_NS = 25000;

    // least times round up, longest times round down, never below one cycle
    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_ceil

    function automatic int cyc_floor(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_floor

    localparam int SOFT_START_CYCLES = cyc_ceil(SOFT_START_TIME_US * 1000);
    localparam int SS_FIXED_SUPP_WINDOW_CYCLES = cyc_ceil(SS_FIXED_SUPP_WINDOW_US * 1000);
    localparam int SS_FIXED_SUPP_CYCLES = cyc_ceil(SS_FIXED_SUPP_TIME_NS);
    localparam int COUNTER_PERIOD_CYCLES = cyc_floor(COUNTER_PERIOD_US * 1000);
    localparam int LINE_SELECT_BLANKING_CYCLES = cyc_ceil(LINE_SELECT_BLANKING_US * 1000);
    localparam int SHORT_SUPPRESSION_CYCLES = cyc_ceil(SHORT_SUPPRESSION_TIME_NS);
    localparam int LONG_SUPPRESSION_CYCLES = cyc_ceil(LONG_SUPPRESSION_TIME_NS);
    localparam int MAX_OFF_CYCLES = cyc_floor(MAX_OFF_TIME_NS);
    localparam int MAX_ON_CYCLES = cyc_floor(MAX_ON_TIME_NS);

    // ------------------------------------------------------------------
    // counter ranges and current-sense limits
    // ------------------------------------------------------------------
    localparam int CNT_W = 4;
    localparam logic [3:0] CNT_MIN_LOW = 4'h1;
    localparam logic [3:0] CNT_MIN_HIGH = 4'h3;
    localparam logic [3:0] CNT_MAX_LOW = 4'h8;
    localparam logic [3:0] CNT_MAX_HIGH = 4'ha;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam int MV_W = 10;
    localparam logic [9:0] CS_LIMIT_START_MV = 10'h12c;
    localparam logic [9:0] CS_LIMIT_FINAL_MV = 10'h3e8;

    typedef enum logic [1:0] {
        GS_IDLE,
        GS_ON,
        GS_SUPPRESS,
        GS_WAIT
    } qrst_gate_state_type;

    function automatic logic [3:0] cnt_min(input logic high_line);
        return high_line ? CNT_MIN_HIGH : CNT_MIN_LOW;
    endfunction : cnt_min

    function automatic logic [3:0] cnt_max(input logic high_line);
        return high_line ? CNT_MAX_HIGH : CNT_MAX_LOW;
    endfunction : cnt_max

    function automatic logic [3:0] cnt_clamp(input logic [3:0] v, input logic high_line);
        if (v < cnt_min(high_line)) begin
            return cnt_min(high_line);
        end
        if (v > cnt_max(high_line)) begin
            return cnt_max(high_line);
        end
        return v;
    endfunction : cnt_clamp

    // equal steps from start level; the last step lands on the final level
    function automatic logic [9:0] step_level(input logic [1:0] step);
        logic [19:0] span;
        span = 20'(CS_LIMIT_FINAL_MV - CS_LIMIT_START_MV) * 20'(step) / 20'(SOFT_START_STEPS - 1);
        return CS_LIMIT_START_MV + span[9:0];
    endfunction : step_level

endpackage : qrst_pkg

// ### verilog/qrst_line_if.sv
// line mode carrier between the line selector and the switch timing core
`timescale 1ns/1ns
`default_nettype none
interface qrst_line_if;
    logic high_line;
    logic changed;
    modport sel (output high_line, output changed);
    modport core (input high_line, input changed);
endinterface : qrst_line_if
`default_nettype wire

// ### verilog/qrst_line_sel.sv
// low/high line selector with hysteresis and blanking
`timescale 1ns/1ns
`default_nettype none
module qrst_line_sel
    import qrst_pkg::*;
#(
    parameter int BLANK_CYCLES = LINE_SELECT_BLANKING_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // line comparators (asynchronous)
    input wire logic i_line_above_ref,
    input wire logic i_line_below_ref,
    // line mode
    qrst_line_if.sel line
);
    localparam int BW = $clog2(BLANK_CYCLES + 1);
    localparam logic [BW-1:0] BLANK_LAST = BW'(BLANK_CYCLES - 1);

    if (BLANK_CYCLES < 1) begin : g_chk
        $error("qrst_line_sel: blanking must be at least one cycle");
    end

    logic [1:0] above_sync_q;
    logic [1:0] below_sync_q;
    logic high_q;
    logic high_d;
    logic changed_q;
    logic changed_d;
    logic [BW-1:0] blank_q;
    logic [BW-1:0] blank_d;
    logic want_switch;

    // two separate thresholds give the hysteresis; the blank counter makes
    // a short line dip or surge unable to flip the mode
    always_comb begin
        want_switch = high_q ? below_sync_q[1] : above_sync_q[1];
        high_d = high_q;
        changed_d = 1'b0;
        blank_d = '0;
        if (want_switch) begin
            if (blank_q == BLANK_LAST) begin
                high_d = ~high_q;
                changed_d = 1'b1;
            end else begin
                blank_d = blank_q + BW'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            above_sync_q <= 2'h0;
            below_sync_q <= 2'h0;
            high_q <= 1'b0;
            changed_q <= 1'b0;
            blank_q <= '0;
        end else if (i_ce) begin
            above_sync_q <= {above_sync_q[0], i_line_above_ref};
            below_sync_q <= {below_sync_q[0], i_line_below_ref};
            high_q <= high_d;
            changed_q <= changed_d;
            blank_q <= blank_d;
        end
    end

    assign line.high_line = high_q;
    assign line.changed = changed_q;

endmodule : qrst_line_sel
`default_nettype wire

// ### testbench/qrst_switch_timing_props.sv
// port checker for the switch timing block
`timescale 1ns/1ns
`default_nettype none
module qrst_switch_timing_props
    import qrst_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_vcc_above_on,
    input wire logic i_cs_above_feedback,
    input wire logic o_gate_drive,
    input wire logic o_soft_start_active,
    input wire logic o_high_line,
    input wire logic [CNT_W-1:0] o_updown_count,
    input wire logic [CNT_W-1:0] o_valley_count
);
    logic [12:0] off_q, on_q;
    logic seen_q;
    logic [3:0] mn, mx;
    assign mn = o_high_line ? CNT_MIN_HIGH : CNT_MIN_LOW;
    assign mx = o_high_line ? CNT_MAX_HIGH : CNT_MAX_LOW;
    // seen_q keeps the first pulse, which needs no valley, out of the switch-on checks
    always_ff @(posedge i_clk) begin
        off_q <= (i_reset || o_gate_drive) ? 13'h0 : off_q + 13'h1;
        on_q <= (i_reset || !o_gate_drive) ? 13'h0 : on_q + 13'h1;
        seen_q <= !i_reset && (seen_q || o_gate_drive);
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    AST_START: assert property ($rose(i_vcc_above_on) |-> ##3 o_gate_drive
        && o_soft_start_active && o_updown_count == mn) else $error("start pulse wrong");
    AST_UD_RANGE: assert property (o_updown_count >= mn && o_updown_count <= mx)
        else $error("up/down count out of range");
    AST_VC_MAX: assert property (o_valley_count <= mx) else $error("valley count too high");
    AST_VC_CLR: assert property (o_gate_drive && $past(o_gate_drive) |-> o_valley_count == CNT_ZERO)
        else $error("valley count kept");
    AST_SUPP: assert property ($rose(o_gate_drive) && seen_q |-> off_q >= 13'(SHORT_SUPPRESSION_CYCLES - 2))
        else $error("gate rose in suppression");
    AST_MATCH: assert property ($rose(o_gate_drive) && seen_q && off_q < 13'(MAX_OFF_CYCLES - 2)
        |-> $past(o_valley_count) == $past(o_updown_count)) else $error("gate rose without match");
    AST_MAX_OFF: assert property (seen_q |-> off_q <= 13'(MAX_OFF_CYCLES + 2)) else $error("off too long");
    AST_MAX_ON: assert property (on_q <= 13'(MAX_ON_CYCLES + 2)) else $error("on too long");
    AST_CS_TRIP: assert property ($rose(i_cs_above_feedback) && o_gate_drive |-> ##[1:4] !o_gate_drive)
        else $error("current trip ignored");
endmodule : qrst_switch_timing_props
bind qrst_switch_timing qrst_switch_timing_props u_qrst_switch_timing_props (.i_clk(i_clk), .i_reset(i_reset),
    .i_vcc_above_on(i_vcc_above_on), .i_cs_above_feedback(i_cs_above_feedback), .o_gate_drive(o_gate_drive),
    .o_soft_start_active(o_soft_start_active), .o_high_line(o_high_line), .o_updown_count(o_updown_count),
    .o_valley_count(o_valley_count));
`default_nettype wire

// ### testbench/qrst_stage_model.sv
// stand-in for the flyback stage: current ramp trip and valley ringing
`timescale 1ns/1ns
`default_nettype none
module qrst_stage_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // gate and stage settings
    input wire logic i_gate_drive,
    input wire logic [11:0] i_on_len,
    input wire logic [11:0] i_ring_half,
    input wire logic i_long_sel,
    // comparator levels
    output logic o_valley_below_detect,
    output logic o_valley_below_select,
    output logic o_cs_above_feedback
);
    logic [11:0] cnt;
    logic g_last;
    always_ff @(posedge i_clk) begin
        g_last <= i_gate_drive;
        cnt <= (i_reset || g_last != i_gate_drive) ? 12'h0 : cnt + 12'h1;
    end
    // zero on_len never trips, so only the on-time limit can end the pulse
    // g_last keeps the count of the previous phase out of the first cycle of the new one
    assign o_cs_above_feedback = i_gate_drive && g_last && i_on_len != 12'h0 && cnt >= i_on_len;
    // zero ring_half is fully damped ringing: no valley is ever seen
    assign o_valley_below_detect = !i_gate_drive && !g_last && i_ring_half != 12'h0
        && cnt / i_ring_half % 12'h2 == 12'h1;
    assign o_valley_below_select = i_long_sel;
endmodule : qrst_stage_model
`default_nettype wire

// ### testbench/qrst_switch_timing_tb.sv
// self-checking bench for the switch timing block
`timescale 1ns/1ns
`default_nettype none
module qrst_switch_timing_tb
    import qrst_pkg::*;
;
    logic i_clk, i_reset, vcc, la, lb, fu, fd, fp, lsel;
    logic [11:0] on_len, ring;
    logic vbd, vbs, csf, gate, ss, hl;
    logic [MV_W-1:0] cs;
    logic [CNT_W-1:0] ud, vc;
    int fail_count = 0;
    int cmp_count = 0;
    int n;
    qrst_switch_timing #(.SS_CYCLES(400), .SS_WINDOW_CYCLES(100), .PERIOD_CYCLES(200), .LINE_BLANK_CYCLES(20))
    u_qrst_switch_timing (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_vcc_above_on(vcc),
        .i_line_above_ref(la), .i_line_below_ref(lb), .i_fb_above_count_up(fu), .i_fb_above_count_down(fd),
        .i_fb_above_preset(fp), .i_valley_below_detect(vbd), .i_valley_below_select(vbs),
        .i_cs_above_feedback(csf), .o_gate_drive(gate), .o_cs_limit_mv(cs), .o_soft_start_active(ss),
        .o_high_line(hl), .o_updown_count(ud), .o_valley_count(vc));
    qrst_stage_model u_qrst_stage_model (.i_clk(i_clk), .i_reset(i_reset), .i_gate_drive(gate), .i_on_len(on_len),
        .i_ring_half(ring), .i_long_sel(lsel), .o_valley_below_detect(vbd), .o_valley_below_select(vbs),
        .o_cs_above_feedback(csf));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait_gate(input logic v);
        n = 0;
        while (gate !== v && n < 4000) begin
            cyc(1);
            n++;
        end
    endtask : wait_gate
    task automatic wait_ud;
        logic [3:0] o;
        o = ud;
        n = 0;
        while (ud === o && n < 500) begin
            cyc(1);
            n++;
        end
    endtask : wait_ud
    task automatic set_line(input logic a);
        @(posedge i_clk);
        la <= a;
        lb <= !a;
    endtask : set_line
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // slow ringing: a short suppression would find the first valley early
    task automatic t_soft;
        @(posedge i_clk);
        vcc <= 1'b1;
        cyc(4);
        chk("start_gate", 10'(gate), 10'h1);
        for (int k = 0; k < 4; k++) begin
            cyc(k == 0 ? 46 : 100);
            chk("ss_level", cs, 10'(300 + 700 * k / 3));
        end
        cyc(100);
        chk("ss_done", 10'(ss), 10'h0);
        wait_gate(1'b1);
        chk("ss_supp", 10'(447 + n >= 1270), 10'h1);
    endtask : t_soft
    task automatic t_supp;
        @(posedge i_clk);
        lsel <= 1'b1;
        ring <= 12'h28;
        wait_gate(1'b0);
        wait_gate(1'b1);
        wait_gate(1'b0);
        wait_gate(1'b1);
        chk("supp_long", 10'(n >= 1248), 10'h1);
        @(posedge i_clk);
        lsel <= 1'b0;
        wait_gate(1'b0);
        wait_gate(1'b1);
        chk("supp_short", 10'(n > 122 && n < 1248), 10'h1);
    endtask : t_supp
    task automatic t_limits;
        @(posedge i_clk);
        on_len <= 12'h0;
        ring <= 12'h0;
        wait_gate(1'b0);
        chk("max_on", 10'(n > 1246 && n < 1254), 10'h1);
        wait_gate(1'b1);
        chk("max_off", 10'(n > 2496 && n < 2504), 10'h1);
        @(posedge i_clk);
        on_len <= 12'h14;
        ring <= 12'h28;
    endtask : t_limits
    task automatic t_updown;
        cyc(1800);
        chk("ud_top", 10'(ud), 10'h8);
        @(posedge i_clk);
        fu <= 1'b1;
        fd <= 1'b1;
        wait_ud;
        chk("ud_down", 10'(ud), 10'h7);
        wait_ud;
        chk("ud_period", 10'(n > 195 && n < 205), 10'h1);
        @(posedge i_clk);
        fd <= 1'b0;
        cyc(450);
        chk("ud_hold", 10'(ud), 10'h5);
        @(posedge i_clk);
        fp <= 1'b1;
        fd <= 1'b1;
        cyc(5);
        chk("ud_preset", 10'(ud), 10'h1);
        @(posedge i_clk);
        fp <= 1'b0;
        cyc(450);
        chk("ud_floor", 10'(ud), 10'h1);
    endtask : t_updown
    task automatic t_line;
        set_line(1'b1);
        cyc(10);
        set_line(1'b0);
        cyc(30);
        chk("line_blank", 10'(hl), 10'h0);
        set_line(1'b1);
        cyc(40);
        chk("line_high", 10'(hl), 10'h1);
        chk("line_clamp", 10'(ud), 10'h3);
        @(posedge i_clk);
        fu <= 1'b0;
        fd <= 1'b0;
        cyc(1800);
        chk("ud_top_high", 10'(ud), 10'ha);
    endtask : t_line
    initial begin
        i_reset = 1'b1;
        vcc = 1'b0;
        la = 1'b0;
        lb = 1'b1;
        fu = 1'b0;
        fd = 1'b0;
        fp = 1'b0;
        lsel = 1'b0;
        on_len = 12'h14;
        ring = 12'hc8;
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        cyc(2);
        chk("rst_cs", cs, 10'h3e8);
        chk("rst_ud", 10'(ud), 10'h1);
        chk("rst_gate", 10'(gate), 10'h0);
        t_soft();
        t_supp();
        t_limits();
        t_updown();
        t_line();
        end_sim();
    end
    initial begin
        cyc(60000);
        fail_count++;
        $display("ERROR watchdog expected finish seen timeout");
        end_sim();
    end
endmodule : qrst_switch_timing_tb
`default_nettype wire
